// *** pra_pkg.sv ***
// Purpose: shared constants and carriers for the paged register addressing block
// Assumes: 8-bit host data, 64 registers, eight pages of eight
// Notes:   access kinds per register are a constant table in the bank
package pra_pkg;
	localparam int ADDR_W        = 6;
	localparam int DATA_W        = 8;
	localparam int NUM_REGS      = 64;
	localparam int PAGE_W        = 3;
	localparam int INPAGE_W      = 3;
	localparam int INPAGE_PAGE   = 3'h0;
	localparam int PAGING_EN_POS = 7;
	localparam int PAGE_NUM_LSB  = 0;
	localparam logic [7:0] PAGE_REG_RESET = 8'h00;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] UNDEF_READ     = 8'h00;

	typedef enum logic [1:0] {
		PRA_ACC_RW,
		PRA_ACC_DYN,
		PRA_ACC_RO,
		PRA_ACC_WO
	} pra_access_e;

	// host side bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic              muxed;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pra_host_req_s;

	// internal state machine port
	typedef struct packed {
		logic [NUM_REGS-1:0]        wr;
		logic [NUM_REGS*DATA_W-1:0] wdata;
	} pra_int_upd_s;
endpackage

// *** pra_reg.sv ***
// Purpose: one 8-bit register cell with host and internal write paths
// Assumes: access kind fixed at elaboration
// Notes:   host write loses to internal update on a dynamic cell
`timescale 1ns/1ps
module pra_reg #(
	parameter pra_pkg::pra_access_e ACCESS = pra_pkg::PRA_ACC_RW
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// write paths
	input  wire logic        host_wr_in,
	input  wire logic [7:0]  host_data_in,
	input  wire logic        int_wr_in,
	input  wire logic [7:0]  int_data_in,
	// stored value
	output logic      [7:0]  value_out
);
	import pra_pkg::*;
	logic [7:0] value;
	logic [7:0] next_value;

	always_comb begin
		next_value = value;
		case (ACCESS)
			PRA_ACC_RW, PRA_ACC_WO: begin
				if (host_wr_in) next_value = host_data_in;
			end
			PRA_ACC_DYN: begin
				if (host_wr_in) next_value = host_data_in;
				if (int_wr_in)  next_value = int_data_in;
			end
			PRA_ACC_RO: begin
				if (int_wr_in) next_value = int_data_in;
			end
			default: next_value = value;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) value <= REG_RESET;
		else           value <= next_value;
	end

	assign value_out = value;
endmodule

// *** pra_bank.sv ***
// Purpose: paged/linear register address decode and 64-entry register bank
// Assumes: host strobes are single-cycle and synchronous to clk_in
// Notes:   page register mirrored at in-page offset 0 of every page
`timescale 1ns/1ps
module pra_bank (
	// clock and reset
	input  wire logic                            clk_in,
	input  wire logic                            rst_n_in,
	// host bus
	input  wire pra_pkg::pra_host_req_s          host_req_in,
	output logic      [pra_pkg::DATA_W-1:0]      host_rdata_out,
	output logic                                 host_rvalid_out,
	// internal state machines
	input  wire pra_pkg::pra_int_upd_s           int_upd_in,
	output logic      [pra_pkg::NUM_REGS*pra_pkg::DATA_W-1:0] reg_values_out,
	// decode visibility
	output logic      [pra_pkg::ADDR_W-1:0]      eff_addr_out,
	output logic                                 paging_enable_bit_out,
	output logic      [pra_pkg::PAGE_W-1:0]      page_number_field_out
);
	import pra_pkg::*;

	logic                rst_meta;
	logic                rst_sync;
	logic [DATA_W-1:0]   page_reg;
	logic [DATA_W-1:0]   next_page_reg;
	logic [DATA_W-1:0]   rdata;
	logic [DATA_W-1:0]   next_rdata;
	logic                rvalid;
	logic                next_rvalid;
	logic [ADDR_W-1:0]   eff_addr;
	logic                page_hit;
	logic                paging_enable_bit;
	logic [PAGE_W-1:0]   page_number_field;
	logic [DATA_W-1:0]   cell_val [NUM_REGS];

	// reset release through two flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	assign paging_enable_bit = page_reg[PAGING_EN_POS];
	assign page_number_field = page_reg[PAGE_NUM_LSB +: PAGE_W];

	// access class per address, one line per register so the map reads as a table
	function automatic pra_access_e access_of(input int idx);
		case (ADDR_W'(idx))
			// page 0: command and status
			6'h00: return PRA_ACC_RW;
			6'h01: return PRA_ACC_DYN;
			6'h02: return PRA_ACC_RW;
			6'h03: return PRA_ACC_RO;
			6'h04: return PRA_ACC_RO;
			6'h05: return PRA_ACC_RO;
			6'h06: return PRA_ACC_RW;
			6'h07: return PRA_ACC_RW;
			// page 1: control and error flags
			6'h08: return PRA_ACC_RW;
			6'h09: return PRA_ACC_RW;
			6'h0a: return PRA_ACC_RO;
			6'h0b: return PRA_ACC_RO;
			6'h0c: return PRA_ACC_RW;
			6'h0d: return PRA_ACC_RW;
			6'h0e: return PRA_ACC_RW;
			6'h0f: return PRA_ACC_RW;
			// page 2
			6'h10: return PRA_ACC_RW;
			6'h11: return PRA_ACC_RW;
			6'h12: return PRA_ACC_RW;
			6'h13: return PRA_ACC_RW;
			6'h14: return PRA_ACC_RW;
			6'h15: return PRA_ACC_RW;
			6'h16: return PRA_ACC_RW;
			6'h17: return PRA_ACC_RW;
			// page 3
			6'h18: return PRA_ACC_RW;
			6'h19: return PRA_ACC_RW;
			6'h1a: return PRA_ACC_RW;
			6'h1b: return PRA_ACC_RW;
			6'h1c: return PRA_ACC_RW;
			6'h1d: return PRA_ACC_RW;
			6'h1e: return PRA_ACC_RW;
			6'h1f: return PRA_ACC_RW;
			// page 4
			6'h20: return PRA_ACC_RW;
			6'h21: return PRA_ACC_RW;
			6'h22: return PRA_ACC_RW;
			6'h23: return PRA_ACC_RW;
			6'h24: return PRA_ACC_RW;
			6'h25: return PRA_ACC_RW;
			6'h26: return PRA_ACC_RW;
			6'h27: return PRA_ACC_RW;
			// page 5
			6'h28: return PRA_ACC_RW;
			6'h29: return PRA_ACC_RW;
			6'h2a: return PRA_ACC_RW;
			6'h2b: return PRA_ACC_RW;
			6'h2c: return PRA_ACC_RW;
			6'h2d: return PRA_ACC_RW;
			6'h2e: return PRA_ACC_RW;
			6'h2f: return PRA_ACC_RW;
			// page 6
			6'h30: return PRA_ACC_RW;
			6'h31: return PRA_ACC_RW;
			6'h32: return PRA_ACC_RW;
			6'h33: return PRA_ACC_RW;
			6'h34: return PRA_ACC_RW;
			6'h35: return PRA_ACC_RW;
			6'h36: return PRA_ACC_RW;
			6'h37: return PRA_ACC_RW;
			// page 7: write-only test controls behind the page alias
			6'h38: return PRA_ACC_RW;
			6'h39: return PRA_ACC_WO;
			6'h3a: return PRA_ACC_WO;
			6'h3b: return PRA_ACC_WO;
			6'h3c: return PRA_ACC_WO;
			6'h3d: return PRA_ACC_WO;
			6'h3e: return PRA_ACC_WO;
			6'h3f: return PRA_ACC_WO;
			default: return PRA_ACC_RW;
		endcase
	endfunction

	// address assembly
	always_comb begin
		if (host_req_in.muxed && !paging_enable_bit) begin
			eff_addr = host_req_in.addr;
		end else if (host_req_in.muxed) begin
			eff_addr = {page_number_field, host_req_in.addr[INPAGE_W-1:0]};
		end else begin
			// dedicated bus: upper pins are not wired, only low three count
			eff_addr = {page_number_field, host_req_in.addr[INPAGE_W-1:0]};
		end
	end

	// offset zero in every page aliases the page register
	assign page_hit = (eff_addr[INPAGE_W-1:0] == INPAGE_W'(INPAGE_PAGE));

	// whole byte kept for readback; only bit 7 and bits 2:0 steer the decode
	always_comb begin
		next_page_reg = page_reg;
		if (host_req_in.wr && page_hit) begin
			next_page_reg = host_req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync) begin
		if (!rst_sync) page_reg <= PAGE_REG_RESET;
		else           page_reg <= next_page_reg;
	end

	// all 64 slots: 56 register cells, the page register at the 8 alias slots
	// internal updates aimed at alias slots are dropped: the page register is host-only
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_cell
			if ((g % 8) == INPAGE_PAGE) begin : g_alias
				assign cell_val[g] = page_reg;
			end else begin : g_reg
				pra_reg #(.ACCESS(access_of(g))) u_reg (
					.clk_in       (clk_in),
					.rst_n_in     (rst_sync),
					.host_wr_in   (host_req_in.wr && (eff_addr == ADDR_W'(g))),
					.host_data_in (host_req_in.wdata),
					.int_wr_in    (int_upd_in.wr[g]),
					.int_data_in  (int_upd_in.wdata[g*DATA_W +: DATA_W]),
					.value_out    (cell_val[g])
				);
			end
			assign reg_values_out[g*DATA_W +: DATA_W] = cell_val[g];
		end
	endgenerate

	// registered read data, one cycle after the read strobe
	always_comb begin
		next_rdata  = rdata;
		next_rvalid = host_req_in.rd;
		if (host_req_in.rd) begin
			// write-only cells keep their contents; only the read path hides them
			if (access_of(int'(eff_addr)) == PRA_ACC_WO && !page_hit) begin
				next_rdata = UNDEF_READ;
			end else begin
				next_rdata = cell_val[eff_addr];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync) begin
		if (!rst_sync) begin
			rdata  <= '0;
			rvalid <= 1'b0;
		end else begin
			rdata  <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	assign host_rdata_out        = rdata;
	assign host_rvalid_out       = rvalid;
	assign eff_addr_out          = eff_addr;
	assign paging_enable_bit_out = paging_enable_bit;
	assign page_number_field_out = page_number_field;
endmodule

// *** pra_bank_asserts.sv ***
// Purpose: port checks on pra_bank
// Assumes: 01h dynamic, 03h read-only, 39h-3Fh write-only
// Notes:   bound to every pra_bank
`timescale 1ns/1ps
module pra_bank_asserts (
	// watched ports
	input wire logic                   clk_in,
	input wire logic                   rst_n_in,
	input wire pra_pkg::pra_host_req_s host_req_in,
	input wire pra_pkg::pra_int_upd_s  int_upd_in,
	input wire logic [7:0]             host_rdata_out,
	input wire logic                   host_rvalid_out,
	input wire logic [511:0]           reg_values_out,
	input wire logic [5:0]             eff_addr_out,
	input wire logic                   paging_enable_bit_out,
	input wire logic [2:0]             page_number_field_out
);
	import pra_pkg::*;
	logic       pg_wr;
	logic [3:0] pg;
	assign pg_wr = host_req_in.wr && eff_addr_out[2:0] == 3'h0;
	assign pg = {paging_enable_bit_out, page_number_field_out};
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_ans; host_req_in.rd |=> host_rvalid_out; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_lin; host_req_in.muxed && !pg[3] |-> eff_addr_out == host_req_in.addr; endproperty
	a_lin: assert property (p_lin) else $error("linear decode wrong");
	property p_pgd; !host_req_in.muxed || pg[3] |-> eff_addr_out == {pg[2:0], host_req_in.addr[2:0]}; endproperty
	a_pgd: assert property (p_pgd) else $error("paged decode wrong");
	property p_set; pg_wr |=> pg == {$past(host_req_in.wdata[7]), $past(host_req_in.wdata[2:0])}; endproperty
	a_set: assert property (p_set) else $error("page not stored");
	property p_hld; !pg_wr |=> $stable(pg); endproperty
	a_hld: assert property (p_hld) else $error("page changed");
	property p_dyn; int_upd_in.wr[1] |=> reg_values_out[15:8] == $past(int_upd_in.wdata[15:8]); endproperty
	a_dyn: assert property (p_dyn) else $error("dynamic update lost");
	property p_ro;
		host_req_in.wr && eff_addr_out == 6'h03 && !int_upd_in.wr[3] |=> $stable(reg_values_out[31:24]);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only changed");
	property p_rw;
		int_upd_in.wr[2] && !(host_req_in.wr && eff_addr_out == 6'h02) |=> $stable(reg_values_out[23:16]);
	endproperty
	a_rw: assert property (p_rw) else $error("read/write changed by internal update");
	property p_wo; host_req_in.rd && eff_addr_out > 6'h38 |=> host_rdata_out == 8'h00; endproperty
	a_wo: assert property (p_wo) else $error("write-only read back");
	c_set: cover property (pg_wr);
	c_wo: cover property (host_req_in.rd && eff_addr_out == 6'h3f);
	c_dyn: cover property (int_upd_in.wr[1]);
endmodule
bind pra_bank pra_bank_asserts u_pra_bank_asserts (
	.clk_in                (clk_in),
	.rst_n_in              (rst_n_in),
	.host_req_in           (host_req_in),
	.int_upd_in            (int_upd_in),
	.host_rdata_out        (host_rdata_out),
	.host_rvalid_out       (host_rvalid_out),
	.reg_values_out        (reg_values_out),
	.eff_addr_out          (eff_addr_out),
	.paging_enable_bit_out (paging_enable_bit_out),
	.page_number_field_out (page_number_field_out)
);

// *** pra_host_model.sv ***
// Purpose: host processor on the bank's bus
// Assumes: one transfer at a time
// Notes:   idle address and data lines show the inverse of the last value; strobes drop low, muxed is held
`timescale 1ns/1ps
module pra_host_model (
	// bus
	input  wire logic              clk_in,
	input  wire logic [7:0]        rdata_in,
	input  wire logic              rvalid_in,
	input  wire logic [5:0]        eff_addr_in,
	output pra_pkg::pra_host_req_s req_out
);
	initial req_out = '0;
	task automatic xfer(input logic w, m, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] d,
		output logic v, output logic [5:0] ea);
		@(negedge clk_in);
		// dedicated bus: upper pins are junk
		req_out = '{w, !w, m, m ? a : {~a[5:3], a[2:0]}, wd};
		// decode taken at the sampling edge, before a page write can move it
		@(posedge clk_in);
		ea = eff_addr_in;
		@(negedge clk_in);
		req_out = '{1'b0, 1'b0, m, ~req_out.addr, ~wd};
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for pra_bank
// Assumes: access map as chosen in the bank
// Notes:   internal updates driven here
`timescale 1ns/1ps
module tb;
	import pra_pkg::*;
	logic          clk_in = 1'b0;
	logic          rst_n_in = 1'b0;
	pra_host_req_s req;
	pra_int_upd_s  iu = '0;
	logic [7:0]    rdata, d;
	logic [511:0]  regs;
	logic          rvalid;
	logic          v;
	logic [5:0]    eff;
	logic [5:0]    ea;
	logic          pg_en;
	logic [2:0]    pg_num;
	int            mismatches = 0;
	int            n_checks = 0;
	int            cyc = 0;
	always #20 clk_in = ~clk_in;
	pra_host_model u_pra_host_model (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .eff_addr_in(eff),
		.req_out(req));
	pra_bank u_pra_bank (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_req_in(req), .host_rdata_out(rdata),
		.host_rvalid_out(rvalid), .int_upd_in(iu), .reg_values_out(regs), .eff_addr_out(eff),
		.paging_enable_bit_out(pg_en), .page_number_field_out(pg_num));
	task automatic chk(input string n, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic m, input logic [5:0] a, input logic [7:0] x);
		u_pra_host_model.xfer(1'b1, m, a, x, d, v, ea);
		chk("rvalid", 8'h00, {7'h00, v});
	endtask
	task automatic rd(input logic m, input logic [5:0] a, input logic [7:0] e);
		u_pra_host_model.xfer(1'b0, m, a, 8'h00, d, v, ea);
		chk("rvalid", 8'h01, {7'h00, v});
		chk("rdata", e, d);
	endtask
	task automatic iup(input int i, input logic [7:0] x);
		@(negedge clk_in);
		iu.wr[i] = 1'b1;
		iu.wdata[i*8+:8] = x;
		@(negedge clk_in);
		iu.wr[i] = 1'b0;
	endtask
	task automatic t_page;
		rd(1'b0, 6'h00, 8'h00);
		wr(1'b1, 6'h2a, 8'h3c);
		rd(1'b1, 6'h2a, 8'h3c);
		for (int p = 0; p < 8; p++) begin
			wr(1'b0, 6'h00, {5'h10, p[2:0]});
			rd(1'b1, {p[2:0], 3'h0}, {5'h10, p[2:0]});
		end
		wr(1'b0, 6'h00, 8'h85);
		wr(1'b0, 6'h03, 8'h5d);
		chk("reg2b", 8'h5d, regs[351:344]);
		rd(1'b1, 6'h3b, 8'h5d);
		wr(1'b0, 6'h00, 8'h00);
		rd(1'b1, 6'h2a, 8'h3c);
	endtask
	task automatic t_decode;
		wr(1'b0, 6'h00, 8'h86);
		chk("eff_addr", 8'h00, {2'b00, ea});
		chk("paging_enable_bit", 8'h01, {7'h00, pg_en});
		chk("page_number_field", 8'h06, {5'h00, pg_num});
		rd(1'b0, 6'h05, 8'h00);
		chk("eff_addr", 8'h35, {2'b00, ea});
		rd(1'b1, 6'h0c, 8'h00);
		chk("eff_addr", 8'h34, {2'b00, ea});
		wr(1'b0, 6'h00, 8'h06);
		chk("eff_addr", 8'h30, {2'b00, ea});
		chk("paging_enable_bit", 8'h00, {7'h00, pg_en});
		chk("page_number_field", 8'h06, {5'h00, pg_num});
		rd(1'b1, 6'h15, 8'h00);
		chk("eff_addr", 8'h15, {2'b00, ea});
	endtask
	task automatic t_kind;
		wr(1'b1, 6'h03, 8'hff);
		rd(1'b1, 6'h03, 8'h00);
		iup(3, 8'h5a);
		rd(1'b1, 6'h03, 8'h5a);
		wr(1'b1, 6'h01, 8'haa);
		iup(1, 8'h33);
		rd(1'b1, 6'h01, 8'h33);
		wr(1'b1, 6'h02, 8'h69);
		iup(2, 8'h96);
		rd(1'b1, 6'h02, 8'h69);
		wr(1'b1, 6'h3f, 8'h77);
		rd(1'b1, 6'h3f, 8'h00);
		chk("reg3f", 8'h77, regs[511:504]);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(posedge clk_in);
		t_page();
		t_decode();
		t_kind();
		end_of_test();
	end
endmodule
